// File: logic/dcp_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "dcp_map.vh"

module dcp_ctrl #(
  parameter [12:0] PAGE_BYTES = 13'h1000
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg read_strobe_n,
  output wire wp_n,
  output reg [7:0] io_out,
  output reg io_oe,
  input wire [7:0] io_in,
  input wire ready_busy_out
);

  // Bus cycle kinds
  localparam [2:0] K_NONE = 3'h0;
  localparam [2:0] K_CMD = 3'h1;
  localparam [2:0] K_ADR = 3'h2;
  localparam [2:0] K_DIN = 3'h3;
  localparam [2:0] K_DOUT = 3'h4;
  localparam [2:0] K_WAIT = 3'h5;

  // Sequencer states
  localparam [4:0] S_IDLE = 5'h00;
  localparam [4:0] S_PCMDA = 5'h01;
  localparam [4:0] S_PADDR = 5'h02;
  localparam [4:0] S_PDATA = 5'h03;
  localparam [4:0] S_PCMDB = 5'h04;
  localparam [4:0] S_WAIT = 5'h05;
  localparam [4:0] S_SCMD = 5'h06;
  localparam [4:0] S_SREAD = 5'h07;
  localparam [4:0] S_RCMD = 5'h08;
  localparam [4:0] S_RADDR = 5'h09;
  localparam [4:0] S_RCMD2 = 5'h0A;
  localparam [4:0] S_RDATA = 5'h0B;
  localparam [4:0] S_DCMD = 5'h0C;
  localparam [4:0] S_DADDR = 5'h0D;
  localparam [4:0] S_DDATA = 5'h0E;
  localparam [4:0] S_XCMD = 5'h0F;
  localparam [4:0] S_RST = 5'h10;

  // Busy-wait length in clocks, cut to the counter width on purpose
  localparam integer TWB_FULL = `DCP_TWB_CYC;
  localparam [12:0] TWB_CYC = TWB_FULL[12:0];

  reg [4:0] st_q;
  reg [4:0] ret_q;
  reg [12:0] cnt_q;
  reg [2:0] ph_q;
  reg [5:0] page_q;
  reg [5:0] last_pg_q;
  reg dist_q;
  reg [1:0] op_q;
  reg mod_q;
  reg wp_q;
  reg [9:0] d0_idx_q;
  reg [9:0] d1_idx_q;
  reg [10:0] src_blk_q;
  reg [10:0] dst_blk_q;
  reg [5:0] src_pg_q;
  reg [5:0] dst_pg_q;
  reg [6:0] count_q;
  reg [7:0] fill_q;
  reg [12:0] mod_col_q;
  reg done_q;
  reg err_q;
  reg fail_q;
  reg [7:0] xstat_q;
  reg [7:0] rbyte_q;
  reg [7:0] io_s1_q;
  reg [7:0] io_s2_q;
  reg rb_s1_q;
  reg rb_s2_q;

  reg [2:0] kind;
  reg [7:0] bval;
  reg [12:0] last;
  reg [16:0] row;
  reg [12:0] col;
  reg [7:0] abyte;
  reg [31:0] rdata_d;

  wire busy = (st_q != S_IDLE);
  wire io_act = (kind == K_CMD) || (kind == K_ADR) || (kind == K_DIN) ||
                (kind == K_DOUT);
  wire rd = (kind == K_DOUT);
  wire cyc_done = io_act && (ph_q == (rd ? 3'h5 : 3'h3));
  wire wait_done = (kind == K_WAIT) && (cnt_q >= TWB_CYC) && rb_s2_q;
  wire step = cyc_done || wait_done;
  wire at_last = (cnt_q == last);
  wire wr_acc = psel && penable && pwrite;
  wire go = wr_acc && (paddr == `DCP_REG_CTRL) && pwdata[`DCP_CTRL_GO] &&
            !busy;
  wire [1:0] go_op = pwdata[`DCP_CTRL_OP_HI:`DCP_CTRL_OP_LO];
  // Copy end pages in 7 bits: a run past the block end is caught unless the sum wraps past 127
  wire [6:0] src_end = {1'b0, src_pg_q} + count_q;
  wire [6:0] dst_end = {1'b0, dst_pg_q} + count_q;
  wire copy_bad = (src_blk_q[0] != dst_blk_q[0]) || (count_q == 7'h00) ||
                  (src_end > `DCP_PAGES_PER_BLK) ||
                  (dst_end > `DCP_PAGES_PER_BLK);

  // Protect released for every operation, copy included
  assign wp_n = wp_q | busy;
  assign pready = 1'b1;
  assign pslverr = psel && penable && (paddr != `DCP_REG_CTRL) &&
                   (paddr != `DCP_REG_BLK) && (paddr != `DCP_REG_COPY) &&
                   (paddr != `DCP_REG_PAGE) && (paddr != `DCP_REG_DATA) &&
                   (paddr != `DCP_REG_STAT);

  // Row and column of the current address phase
  always @* begin
    row = 17'h00000;
    col = 13'h0000;
    if (st_q == S_PADDR) begin
      // Even block index in district 0, odd in district 1, same page
      if (dist_q) begin
        row = {d1_idx_q, 1'b1, page_q};
      end else begin
        row = {d0_idx_q, 1'b0, page_q};
      end
    end else if (st_q == S_RADDR) begin
      row = {src_blk_q, src_pg_q + page_q};
    end else if (st_q == S_DADDR) begin
      row = {dst_blk_q, dst_pg_q + page_q};
      col = mod_q ? mod_col_q : 13'h0000;
    end
    case (cnt_q[2:0])
      3'h0: abyte = col[7:0];
      3'h1: abyte = {3'h0, col[12:8]};
      3'h2: abyte = row[7:0];
      3'h3: abyte = row[15:8];
      default: abyte = {7'h00, row[16]};
    endcase
  end

  // What the current state puts on the pins
  always @* begin
    kind = K_NONE;
    bval = 8'h00;
    last = 13'h0000;
    case (st_q)
      S_PCMDA: begin
        kind = K_CMD;
        bval = dist_q ? `DCP_CMD_SETUP2 : `DCP_CMD_SETUP1;
      end
      S_PADDR: begin
        kind = K_ADR;
        bval = abyte;
        last = 13'h0004;
      end
      S_PDATA: begin
        kind = K_DIN;
        bval = fill_q;
        last = PAGE_BYTES - 13'h0001;
      end
      S_PCMDB: begin
        kind = K_CMD;
        if (!dist_q) begin
          bval = `DCP_CMD_DUMMY;
        end else if (page_q == `DCP_LAST_PAGE) begin
          bval = `DCP_CMD_FINAL;
        end else begin
          bval = `DCP_CMD_CACHE;
        end
      end
      S_WAIT: kind = K_WAIT;
      S_SCMD: begin
        kind = K_CMD;
        bval = `DCP_CMD_XSTAT;
      end
      S_SREAD: kind = K_DOUT;
      S_RCMD: begin
        kind = K_CMD;
        bval = `DCP_CMD_READ1;
      end
      S_RADDR: begin
        kind = K_ADR;
        bval = abyte;
        last = 13'h0004;
      end
      S_RCMD2: begin
        kind = K_CMD;
        bval = `DCP_CMD_READ2;
      end
      S_RDATA: begin
        kind = K_DOUT;
        last = PAGE_BYTES - 13'h0001;
      end
      S_DCMD: begin
        kind = K_CMD;
        bval = `DCP_CMD_DEST;
      end
      S_DADDR: begin
        kind = K_ADR;
        bval = abyte;
        last = 13'h0004;
      end
      S_DDATA: begin
        kind = K_DIN;
        bval = fill_q;
      end
      S_XCMD: begin
        kind = K_CMD;
        // Final page of the chain closes it, others keep it cached
        bval = (page_q == last_pg_q) ? `DCP_CMD_FINAL :
               `DCP_CMD_CACHE;
      end
      S_RST: begin
        kind = K_CMD;
        bval = `DCP_CMD_RESET;
      end
      default: kind = K_NONE;
    endcase
  end

  // Pin inputs pass two flops before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      io_s1_q <= io_in;
      io_s2_q <= io_s1_q;
      rb_s1_q <= ready_busy_out;
      rb_s2_q <= rb_s1_q;
    end
  end

  // Strobe engine: writes latch on the rising write strobe at phase 2;
  // reads hold the read strobe low long enough to cover the synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 3'h0;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      ce_n <= !busy;
      if (io_act) begin
        ph_q <= cyc_done ? 3'h0 : ph_q + 3'h1;
        if (ph_q == 3'h0) begin
          cle <= (kind == K_CMD);
          ale <= (kind == K_ADR);
          io_out <= bval;
          io_oe <= !rd;
        end
        we_n <= !(!rd && (ph_q < 3'h2));
        read_strobe_n <= !(rd && (ph_q < 3'h4));
      end else begin
        ph_q <= 3'h0;
        cle <= 1'b0;
        ale <= 1'b0;
        we_n <= 1'b1;
        read_strobe_n <= 1'b1;
        io_oe <= 1'b0;
      end
    end
  end

  // Configuration registers, written only while idle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 2'h0;
      mod_q <= 1'b0;
      wp_q <= 1'b0;
      d0_idx_q <= 10'h000;
      d1_idx_q <= 10'h000;
      src_blk_q <= 11'h000;
      dst_blk_q <= 11'h000;
      src_pg_q <= 6'h00;
      dst_pg_q <= 6'h00;
      count_q <= 7'h00;
      fill_q <= 8'h00;
      mod_col_q <= 13'h0000;
    end else if (wr_acc && !busy) begin
      // Changing setup mid-run would break the block rules, so hold it
      if (paddr == `DCP_REG_CTRL) begin
        op_q <= go_op;
        mod_q <= pwdata[`DCP_CTRL_MOD];
        wp_q <= pwdata[`DCP_CTRL_WP];
      end else if (paddr == `DCP_REG_BLK) begin
        d0_idx_q <= pwdata[9:0];
        d1_idx_q <= pwdata[25:16];
      end else if (paddr == `DCP_REG_COPY) begin
        src_blk_q <= pwdata[10:0];
        dst_blk_q <= pwdata[26:16];
      end else if (paddr == `DCP_REG_PAGE) begin
        src_pg_q <= pwdata[5:0];
        dst_pg_q <= pwdata[13:8];
        count_q <= pwdata[22:16];
      end else if (paddr == `DCP_REG_DATA) begin
        fill_q <= pwdata[7:0];
        mod_col_q <= pwdata[28:16];
      end
    end
  end

  // Read mux
  always @* begin
    rdata_d = 32'h00000000;
    if (paddr == `DCP_REG_CTRL) begin
      rdata_d = {27'h0000000, wp_q, mod_q, op_q, 1'b0};
    end else if (paddr == `DCP_REG_BLK) begin
      rdata_d = {6'h00, d1_idx_q, 6'h00, d0_idx_q};
    end else if (paddr == `DCP_REG_COPY) begin
      rdata_d = {5'h00, dst_blk_q, 5'h00, src_blk_q};
    end else if (paddr == `DCP_REG_PAGE) begin
      rdata_d = {9'h000, count_q, 2'h0, dst_pg_q, 2'h0, src_pg_q};
    end else if (paddr == `DCP_REG_DATA) begin
      rdata_d = {3'h0, mod_col_q, 8'h00, fill_q};
    end else if (paddr == `DCP_REG_STAT) begin
      rdata_d = {2'h0, page_q, rbyte_q, xstat_q, 4'h0, fail_q, err_q,
                 done_q, busy};
    end
  end

  // Read data taken in the setup cycle: it comes from a flop and still
  // stands through the zero-wait access cycle; status is one clock old
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= rdata_d;
    end
  end

  // Sequencer: only the listed commands are ever issued once started
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_IDLE;
      ret_q <= S_IDLE;
      cnt_q <= 13'h0000;
      page_q <= 6'h00;
      last_pg_q <= 6'h00;
      dist_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
      fail_q <= 1'b0;
      xstat_q <= 8'h00;
      rbyte_q <= 8'h00;
    end else if (st_q == S_IDLE) begin
      cnt_q <= 13'h0000;
      if (go) begin
        page_q <= 6'h00;
        dist_q <= 1'b0;
        done_q <= 1'b0;
        err_q <= 1'b0;
        fail_q <= 1'b0;
        if (go_op == `DCP_OP_PROG) begin
          last_pg_q <= `DCP_LAST_PAGE;
          st_q <= S_PCMDA;
        end else if (go_op == `DCP_OP_COPY) begin
          if (copy_bad) begin
            err_q <= 1'b1;
            done_q <= 1'b1;
          end else begin
            last_pg_q <= count_q[5:0] - 6'h01;
            st_q <= S_RCMD;
          end
        end else if (go_op == `DCP_OP_STAT) begin
          st_q <= S_SCMD;
        end else begin
          st_q <= S_RST;
        end
      end
    end else begin
      if (kind == K_WAIT) begin
        cnt_q <= wait_done ? 13'h0000 : cnt_q + 13'h0001;
      end else if (cyc_done) begin
        cnt_q <= at_last ? 13'h0000 : cnt_q + 13'h0001;
      end
      if (cyc_done && (st_q == S_RDATA)) begin
        rbyte_q <= io_s2_q;
      end
      if (step && (at_last || (kind == K_WAIT))) begin
        case (st_q)
          S_PCMDA: st_q <= S_PADDR;
          S_PADDR: st_q <= S_PDATA;
          S_PDATA: st_q <= S_PCMDB;
          S_PCMDB: begin
            st_q <= S_WAIT;
            dist_q <= 1'b1;
            // After the dummy command the next one is the second setup
            ret_q <= dist_q ? S_SCMD : S_PCMDA;
          end
          S_WAIT: st_q <= ret_q;
          S_SCMD: st_q <= S_SREAD;
          S_SREAD: begin
            xstat_q <= io_s2_q;
            if (io_s2_q[0]) begin
              fail_q <= 1'b1;
            end
            dist_q <= 1'b0;
            if ((op_q == `DCP_OP_STAT) || (page_q == last_pg_q)) begin
              st_q <= S_IDLE;
              done_q <= 1'b1;
            end else begin
              page_q <= page_q + 6'h01;
              st_q <= (op_q == `DCP_OP_COPY) ? S_RCMD : S_PCMDA;
            end
          end
          // Later pages already sit in the cache, so skip the load
          S_RCMD: st_q <= (page_q == 6'h00) ? S_RADDR : S_RDATA;
          S_RADDR: st_q <= S_RCMD2;
          S_RCMD2: begin
            st_q <= S_WAIT;
            ret_q <= S_RDATA;
          end
          S_RDATA: st_q <= S_DCMD;
          S_DCMD: st_q <= S_DADDR;
          S_DADDR: st_q <= mod_q ? S_DDATA : S_XCMD;
          S_DDATA: st_q <= S_XCMD;
          S_XCMD: begin
            st_q <= S_WAIT;
            ret_q <= S_SCMD;
          end
          S_RST: begin
            st_q <= S_WAIT;
            ret_q <= S_IDLE;
            done_q <= 1'b1;
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// File: logic/dcp_map.vh
// Contract
// - Full block: 64 two-district steps from page 0
// - Close multi-page program with 81h then 10h
// - At most one block per district
// - Same in-block page bits both districts
// - Step is 80h, 11h, 81h, then 15h/10h
// - Only sequence, status or reset commands meanwhile
// - Block change restarts the whole sequence
// - Copy stays inside one district
// - After 8Ch: address, optional changed bytes only
// - Write protect held high during copy
// - End copy with 8Ch then 10h
// - Between 11h and 81h only status or reset
`ifndef DCP_MAP_VH
`define DCP_MAP_VH

// Register offsets (byte addresses)
`define DCP_REG_CTRL 12'h000
`define DCP_REG_BLK 12'h004
`define DCP_REG_COPY 12'h008
`define DCP_REG_PAGE 12'h00C
`define DCP_REG_DATA 12'h010
`define DCP_REG_STAT 12'h014

// Control fields
`define DCP_CTRL_GO 0
`define DCP_CTRL_OP_LO 1
`define DCP_CTRL_OP_HI 2
`define DCP_CTRL_MOD 3
`define DCP_CTRL_WP 4

// Operations
`define DCP_OP_PROG 2'h0
`define DCP_OP_COPY 2'h1
`define DCP_OP_STAT 2'h2
`define DCP_OP_RST 2'h3

// Command bytes
`define DCP_CMD_SETUP1 8'h80
`define DCP_CMD_DUMMY 8'h11
`define DCP_CMD_SETUP2 8'h81
`define DCP_CMD_CACHE 8'h15
`define DCP_CMD_FINAL 8'h10
`define DCP_CMD_XSTAT 8'h71
`define DCP_CMD_READ1 8'h00
`define DCP_CMD_READ2 8'h30
`define DCP_CMD_DEST 8'h8C
`define DCP_CMD_RESET 8'hFF

// Geometry
`define DCP_PAGES_PER_BLK 7'h40
`define DCP_LAST_PAGE 6'h3F

// Timing: wait before sampling ready/busy after a busy command
`define DCP_TWB_NS 100
`define DCP_CLK_NS 10
`define DCP_TWB_CYC ((`DCP_TWB_NS + `DCP_CLK_NS - 1) / `DCP_CLK_NS)

`endif

// File: testbench/dcp_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module dcp_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  input wire io_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic we_q;
  logic [7:0] last_cmd_q;
  wire cmd_end = we_n & ~we_q & cle;
  // Track the last command byte the die latched
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      we_q <= 1'h1;
      last_cmd_q <= 8'hFF;
    end else begin
      we_q <= we_n;
      if (cmd_end) last_cmd_q <= io_out;
    end
  end
  chk_apb_ready: assert property (psel && penable |-> pready)
    else $error("apb access not answered");
  chk_unmapped_err: assert property (psel && penable && paddr > 12'h014
    |-> pslverr && prdata == 32'h00000000) else $error("unmapped not refused");
  chk_strobe_width: assert property ($fell(we_n) |=> !we_n ##1 we_n)
    else $error("write strobe width wrong");
  chk_read_width: assert property ($fell(read_strobe_n)
    |=> !read_strobe_n [*3] ##1 read_strobe_n) else $error("read width wrong");
  chk_latch_stable: assert property ($rose(we_n) |-> io_oe && $stable(io_out)
    && $stable(cle) && $stable(ale)) else $error("latched byte moved");
  chk_no_clash: assert property (!read_strobe_n |-> !io_oe && !ce_n)
    else $error("bus driven while reading");
  chk_wp_high: assert property (!we_n || !read_strobe_n |-> wp_n)
    else $error("write protect low during an operation");
  chk_busy_gap: assert property (cmd_end && io_out inside {8'h11, 8'h15,
    8'h10, 8'h30, 8'hFF} |=> we_n [*8]) else $error("busy wait skipped");
  chk_dummy_next: assert property (cmd_end && last_cmd_q == 8'h11
    |-> io_out inside {8'h81, 8'h71, 8'hFF}) else $error("bad after dummy");
  chk_setup_next: assert property (cmd_end && last_cmd_q == 8'h80
    |-> io_out inside {8'h11, 8'h71, 8'hFF}) else $error("bad after setup");
  chk_final_prior: assert property (cmd_end && io_out == 8'h10
    |-> last_cmd_q inside {8'h81, 8'h8C}) else $error("final after wrong cmd");
  cover property (cmd_end && io_out == 8'h10);
  cover property (cmd_end && io_out == 8'h8C);
  cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

// File: testbench/dcp_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural die: bytes are latched on the write strobe rising edge
module dcp_flash_model (
  input wire ce_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire read_strobe_n,
  input wire wp_n,
  input wire [7:0] io_out,
  output logic [7:0] io_dev,
  output logic ready_busy_out,
  input wire slow,
  input wire fail_d1
);
  logic [7:0] cmd_q = 8'hFF, mod_q = 8'h00;
  logic [16:0] row_q = 17'h00000, row0_q = 17'h00000;
  logic [16:0] src_q = 17'h00000, last_row = 17'h00000;
  logic [12:0] col_q = 13'h0000, mod_col = 13'h0000;
  logic [5:0] pg_q = 6'h00;
  logic [2:0] acnt = 3'h0;
  logic cur0 = 1'h0, cur1 = 1'h0, prv0 = 1'h0, prv1 = 1'h0, st_mode = 1'h0;
  int prog_cnt = 0, seq_err = 0, cmd_cnt = 0;
  wire [7:0] byte_w = src_q[7:0] + col_q[7:0];
  initial ready_busy_out = 1'h1;
  // Slow mode outlasts the controller's fixed wait, so it must poll
  task automatic go_busy;
    ready_busy_out <= 1'h0;
    ready_busy_out <= #(slow ? 400 : 60) 1'h1;
  endtask
  // Command, address and data cycles
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd_cnt++;
      case (io_out)
        8'h11: begin
          if (cmd_q != 8'h80 || row_q[5:0] != pg_q) seq_err++;
          row0_q = row_q;
          go_busy;
        end
        8'h81: if (cmd_q != 8'h11) seq_err++;
        8'h15, 8'h10: begin
          if (cmd_q == 8'h81) begin
            // District is block bit 0; either order accepted
            if (row_q[5:0] != row0_q[5:0] || row_q[6] == row0_q[6]) seq_err++;
            if ((io_out == 8'h10) != (pg_q == 6'h3F)) seq_err++;
            pg_q++;
            prog_cnt += 2;
          end else if (cmd_q == 8'h8C) begin
            if (row_q[6] != src_q[6]) seq_err++;
            prog_cnt++;
            src_q++;
          end else seq_err++;
          last_row = row_q;
          // One pass stands for the internal program and verify loop
          {prv1, prv0} = {cur1, cur0};
          {cur1, cur0} = {fail_d1 & row_q[6], 1'h0};
          go_busy;
        end
        8'h30: begin
          src_q = row_q;
          go_busy;
        end
        8'h71: st_mode = 1'h1;
        8'h00: st_mode = 1'h0;
        8'hFF: go_busy;
        default: ;
      endcase
      cmd_q = io_out;
      acnt = 3'h0;
      col_q = 13'h0000;
    end else if (!ce_n && ale) begin
      case (acnt)
        3'h0: col_q[7:0] = io_out;
        3'h1: col_q[12:8] = io_out[4:0];
        3'h2: row_q[7:0] = io_out;
        3'h3: row_q[15:8] = io_out;
        default: row_q[16] = io_out[0];
      endcase
      acnt++;
    end else if (!ce_n) begin
      mod_q = io_out;
      mod_col = col_q;
      col_q++;
    end
  end
  // Released bus shows a changing pattern, never a held value
  always @* begin
    if (!ce_n && !read_strobe_n) begin
      io_dev = st_mode ? {wp_n, ready_busy_out, ready_busy_out, prv1, prv0,
        cur1, cur0, cur0 | cur1} : byte_w;
    end else begin
      io_dev = ~byte_w;
    end
  end
  always @(posedge read_strobe_n) begin
    if (!st_mode) col_q++;
  end
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 1'h0;
  logic presetn, psel, penable, pwrite, slow, fail_d1, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, st, q;
  wire [31:0] prdata;
  wire pready, pslverr, ce_n, cle, ale, we_n, read_strobe_n, wp_n, io_oe;
  wire ready_busy_out;
  wire [7:0] io_out, io_dev;
  wire [7:0] io_bus = io_oe ? io_out : io_dev;
  int fails = 0, check_count = 0, cyc = 0, n;
  always #5 pclk = ~pclk;
  dcp_ctrl #(.PAGE_BYTES(13'h0004)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .wp_n(wp_n),
    .read_strobe_n(read_strobe_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_bus), .ready_busy_out(ready_busy_out));
  dcp_flash_model fm (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_bus),
    .io_dev(io_dev), .ready_busy_out(ready_busy_out), .slow(slow),
    .fail_d1(fail_d1));
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer, then an idle cycle so psel is never set twice at once
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] rq);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rq = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'h1, a, d, q);
  endtask
  // Poll until done and idle; only the bench timeout ends a hang
  task automatic wait_done;
    st = 32'h00000000;
    while (st[1:0] !== 2'h2) apb(1'h0, 12'h014, 32'h00000000, st);
  endtask
  task automatic s_regs;
    wr(12'h000, 32'h00000010);
    compare(wp_n, 1'h1);
    apb(1'h0, 12'h000, 32'h00000000, q);
    compare(q, 32'h00000010);
    compare(perr, 1'h0);
    wr(12'h000, 32'h00000000);
    compare(wp_n, 1'h0);
    apb(1'h0, 12'h020, 32'h00000000, q);
    compare(q, 32'h00000000);
    compare(perr, 1'h1);
  endtask
  task automatic s_status;
    wr(12'h000, 32'h00000005);
    wait_done;
    compare(st[15:8], 8'hE0);
  endtask
  // Full block from page 0, boundary blocks 0 and 2047, district 1 failing
  task automatic s_prog;
    fail_d1 <= 1'h1;
    slow <= 1'h1;
    wr(12'h004, 32'h03FF0000);
    wr(12'h000, 32'h00000001);
    wait_done;
    compare(st[15:8], 8'hF5);
    compare(st[3], 1'h1);
    compare(fm.prog_cnt, 128);
    compare(fm.seq_err, 0);
    compare(fm.last_row, 17'h1FFFF);
    compare(fm.row0_q, 17'h0003F);
  endtask
  // Three-page modified copy, block 4 pages 2..4 to block 8 pages 5..7
  task automatic s_copy;
    fail_d1 <= 1'h0;
    slow <= 1'h0;
    wr(12'h008, 32'h00080004);
    wr(12'h00C, 32'h00030502);
    wr(12'h010, 32'h0002005A);
    n = fm.prog_cnt;
    wr(12'h000, 32'h0000000B);
    wait_done;
    compare(st[2], 1'h0);
    compare(st[23:16], 8'h07);
    compare(fm.prog_cnt - n, 3);
    compare(fm.last_row, 17'h00207);
    compare({fm.mod_col, fm.mod_q}, {13'h0002, 8'h5A});
    compare(fm.seq_err, 0);
    // One-page plain copy: no data cycles, so the last changed byte stays
    wr(12'h00C, 32'h00010000);
    wr(12'h010, 32'h00000033);
    wr(12'h000, 32'h00000003);
    wait_done;
    compare(fm.last_row, 17'h00200);
    compare(fm.mod_q, 8'h5A);
  endtask
  // Refused copies leave the pins silent
  task automatic s_refuse;
    logic [31:0] cp [3] = '{32'h00090004, 32'h00080004, 32'h00080004};
    logic [31:0] pg [3] = '{32'h00010000, 32'h0003003E, 32'h00000000};
    for (int i = 0; i < 3; i++) begin
      wr(12'h008, cp[i]);
      wr(12'h00C, pg[i]);
      n = fm.cmd_cnt;
      wr(12'h000, 32'h00000003);
      wait_done;
      compare(st[2], 1'h1);
      compare(fm.cmd_cnt, n);
    end
  endtask
  task automatic s_reset;
    wr(12'h000, 32'h00000007);
    wait_done;
    compare(fm.cmd_q, 8'hFF);
  endtask
  // Cut a hang short well above the longest expected run
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 90000) begin
      fails++;
      test_done;
    end
  end
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, slow, fail_d1} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    s_regs;
    s_status;
    s_prog;
    s_copy;
    s_refuse;
    s_reset;
    test_done;
  end
endmodule
bind dcp_ctrl dcp_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
  .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out),
  .io_oe(io_oe));
`default_nettype wire
